// ===== logic/port_drive_defs.vh
// offsets, field positions, masks and reset values for the port drive control block
`ifndef PORT_DRIVE_DEFS_VH
`define PORT_DRIVE_DEFS_VH

`define PORT_A_DRIVE_OFS      8'h08
`define PORT_B_DRIVE_OFS      8'h09
`define PORT_A_OE_OFS         8'h0C
`define PORT_B_OE_OFS         8'h0D
`define PORT_C_DRIVE_OFS      8'h16
`define PORT_D_DRIVE_OFS      8'h17
`define PORT_C_OE_OFS         8'h1A
`define PORT_D_OE_OFS         8'h1B

`define DRIVE_RESET           8'h00
`define READ_UNMAPPED         8'h00

`define AB_OD_MASK            8'hF0
`define AB_SLEW_MASK          8'h0F
`define C_OD_MASK             8'h9C
`define C_PIN_MASK            8'h9C
`define D_SLEW_MASK_LARGE     8'h06
`define D_SLEW_MASK_SMALL     8'h02
`define D_PIN_MASK_LARGE      8'h06
`define D_PIN_MASK_SMALL      8'h02

`define REPEATER_ENABLE_POS   7

`endif

// ===== logic/port_pin_cell.v
// output stage of one port pin: drive type, final enable and registered pin signals
`timescale 1ns/1ps

module port_pin_cell #(
  parameter PRESENT      = 1,
  parameter OD_CAPABLE   = 0,
  parameter SLEW_CAPABLE = 0
) (
  input  wire clk,        // processor clock
  input  wire reset,      // asynchronous reset, active high
  input  wire drive_sel,  // drive-select bit of this pin
  input  wire oe_request, // combined output enable request
  input  wire data_out,   // level to place on the pin
  output reg  pin_out,    // pad output level
  output reg  pin_oe_n,   // pad enable, low while driving
  output reg  slew_fast,  // pad fast slew select
  output reg  oe_state    // final enable for read-back
);

  wire enable_now;
  wire open_drain;

  assign enable_now = (PRESENT != 0) && oe_request;
  assign open_drain = (OD_CAPABLE != 0) && drive_sel;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out   <= 1'b0;
      pin_oe_n  <= 1'b1;
      slew_fast <= 1'b0;
      oe_state  <= 1'b0;
    end else begin
      oe_state  <= enable_now;
      slew_fast <= (PRESENT != 0) && (SLEW_CAPABLE != 0) && drive_sel;
      if (open_drain) begin
        // open drain only ever pulls low; a high level releases the pad
        pin_out  <= 1'b0;
        pin_oe_n <= ~(enable_now && !data_out);
      end else begin
        // an absent pin keeps its pad low as well as undriven
        pin_out  <= (PRESENT != 0) && data_out;
        pin_oe_n <= ~enable_now;
      end
    end
  end

endmodule

// ===== logic/port_repeater_and_drive_ctl.v
// port pin control: data repeater on port a, drive-type registers, enable read-back
`timescale 1ns/1ps
`include "port_drive_defs.vh"

// Summary of operation
// - port a buffers data byte, strobes set direction
// - repeater exists only in large package
// - repeater active when either range select asserted
// - repeater needs enable bit seven set
// - repeater mode covers all eight port a pins
// - repeater runs only while address in decoded range
// - repeater port serves no other function
// - four port c pins reserved for test port
// - drive type writable at run time, default push-pull
// - open-drain bit one makes pin pull low only
// - slew bit one selects fast slew driver
// - port a: bits 7-4 open drain, 3-0 slew
// - port b uses same drive layout
// - port c: bits 7,4,3,2 open drain only
// - port d: bits 2,1 slew, bit 2 large only
// - drive registers clear to zero at reset
// - processor reads each pin enable, one means driving
// - pin enable from array term, direction, repeater
// - read-back shows final combined pin enable
// - pin enable is OR of direction and array term, or the repeater write alone on a repeater port a
// - enable read-back at 0Ch, 0Dh, 1Ah, 1Bh
module port_repeater_and_drive_ctl #(
  parameter LARGE_PACKAGE = 1,
  parameter PORT_WIDTH    = 8
) (
  input  wire                  clk,                // processor clock, 100 MHz
  input  wire                  reset,              // asynchronous reset, active high
  input  wire [7:0]            cfg_addr,           // configuration window offset
  input  wire [7:0]            cfg_wdata,          // configuration write data
  input  wire                  cfg_wr,             // configuration write strobe
  input  wire                  cfg_rd,             // configuration read strobe
  output reg  [7:0]            cfg_rdata,          // configuration read data
  input  wire [7:0]            memory_map_ctl,     // memory-map control register value
  input  wire                  port_a_repeater_mode, // static: port a chosen as repeater
  input  wire                  periph_range_sel_a, // decode output, first range
  input  wire                  periph_range_sel_b, // decode output, second range
  input  wire                  cpu_rd_n,           // processor read strobe, active low
  input  wire                  cpu_wr_n,           // processor write strobe, active low
  input  wire [7:0]            cpu_wr_data,        // demultiplexed processor write byte
  output reg  [7:0]            repeater_rd_data,   // byte read from port a for the processor
  output wire                  repeater_rd_drive,  // repeater presents read data
  input  wire [PORT_WIDTH-1:0] port_a_data,        // data register levels, port a
  input  wire [PORT_WIDTH-1:0] port_a_dir,         // direction bits, port a
  input  wire [PORT_WIDTH-1:0] port_a_array_oe,    // logic-array enable terms, port a
  input  wire [PORT_WIDTH-1:0] port_a_pin_in,      // pad input levels, port a
  output wire [PORT_WIDTH-1:0] port_a_pin_out,     // pad output levels, port a
  output wire [PORT_WIDTH-1:0] port_a_pin_oe_n,    // pad enables, port a, low drives
  output wire [PORT_WIDTH-1:0] port_a_slew_fast,   // fast slew selects, port a
  input  wire [PORT_WIDTH-1:0] port_b_data,        // data register levels, port b
  input  wire [PORT_WIDTH-1:0] port_b_dir,         // direction bits, port b
  input  wire [PORT_WIDTH-1:0] port_b_array_oe,    // logic-array enable terms, port b
  output wire [PORT_WIDTH-1:0] port_b_pin_out,     // pad output levels, port b
  output wire [PORT_WIDTH-1:0] port_b_pin_oe_n,    // pad enables, port b, low drives
  output wire [PORT_WIDTH-1:0] port_b_slew_fast,   // fast slew selects, port b
  input  wire [7:0]            port_c_data,        // data register levels, port c
  input  wire [7:0]            port_c_dir,         // direction bits, port c
  input  wire [7:0]            port_c_array_oe,    // logic-array enable terms, port c
  output wire [7:0]            port_c_pin_out,     // pad output levels, port c
  output wire [7:0]            port_c_pin_oe_n,    // pad enables, port c, low drives
  input  wire [7:0]            port_d_data,        // data register levels, port d
  input  wire [7:0]            port_d_dir,         // direction bits, port d
  input  wire [7:0]            port_d_array_oe,    // logic-array enable terms, port d
  output wire [7:0]            port_d_pin_out,     // pad output levels, port d
  output wire [7:0]            port_d_pin_oe_n,    // pad enables, port d, low drives
  output wire [7:0]            port_d_slew_fast    // fast slew selects, port d
);

  localparam [7:0] D_SLEW_MASK = (LARGE_PACKAGE != 0) ? `D_SLEW_MASK_LARGE : `D_SLEW_MASK_SMALL;
  localparam [7:0] D_PIN_MASK  = (LARGE_PACKAGE != 0) ? `D_PIN_MASK_LARGE : `D_PIN_MASK_SMALL;

  reg  [7:0] port_a_drive_type;
  reg  [7:0] port_b_drive_type;
  reg  [7:0] port_c_drive_type;
  reg  [7:0] port_d_drive_type;
  reg  [7:0] next_rdata;

  wire       repeater_port;
  wire       repeater_enabled;
  wire       range_hit;
  wire       repeater_active;
  wire       repeater_write;
  wire       hit_a_drive;
  wire       hit_b_drive;
  wire       hit_c_drive;
  wire       hit_d_drive;
  wire       hit_a_oe;
  wire       hit_b_oe;
  wire       hit_c_oe;
  wire       hit_d_oe;
  wire [7:0] next_port_a_drive_type;
  wire [7:0] next_port_b_drive_type;
  wire [7:0] next_port_c_drive_type;
  wire [7:0] next_port_d_drive_type;

  wire [PORT_WIDTH-1:0] port_a_oe_req;
  wire [PORT_WIDTH-1:0] port_a_level;
  wire [PORT_WIDTH-1:0] port_a_oe_state;
  wire [PORT_WIDTH-1:0] port_b_oe_req;
  wire [PORT_WIDTH-1:0] port_b_oe_state;
  wire [7:0]            port_c_oe_req;
  wire [7:0]            port_c_oe_state;
  wire [7:0]            port_d_oe_req;
  wire [7:0]            port_d_oe_state;
  wire [PORT_WIDTH-1:0] port_a_rd_byte;
  wire [PORT_WIDTH-1:0] port_a_normal_oe;

  // repeater: the whole of port a follows the processor strobes
  assign repeater_port    = (LARGE_PACKAGE != 0) && port_a_repeater_mode;
  assign repeater_enabled = memory_map_ctl[`REPEATER_ENABLE_POS];
  assign range_hit        = periph_range_sel_a | periph_range_sel_b;
  assign repeater_active  = repeater_port && repeater_enabled && range_hit;
  assign repeater_write   = repeater_active && !cpu_wr_n;
  assign repeater_rd_drive = repeater_active && !cpu_rd_n && cpu_wr_n;

  // a repeater port ignores direction, array terms and data registers
  assign port_a_normal_oe = port_a_array_oe | port_a_dir;
  assign port_a_oe_req    = repeater_port ? {PORT_WIDTH{repeater_write}} : port_a_normal_oe;
  assign port_a_level  = repeater_port ? cpu_wr_data[PORT_WIDTH-1:0] : port_a_data;
  assign port_b_oe_req = port_b_array_oe | port_b_dir;
  assign port_c_oe_req = port_c_array_oe | port_c_dir;
  assign port_d_oe_req = port_d_array_oe | port_d_dir;

  assign port_a_rd_byte = port_a_pin_in;

  // one match line per mapped offset; the drive lines are shared by the write and read decode, the enable lines serve the read decode only
  assign hit_a_drive = (cfg_addr == `PORT_A_DRIVE_OFS);
  assign hit_b_drive = (cfg_addr == `PORT_B_DRIVE_OFS);
  assign hit_c_drive = (cfg_addr == `PORT_C_DRIVE_OFS);
  assign hit_d_drive = (cfg_addr == `PORT_D_DRIVE_OFS);
  assign hit_a_oe    = (cfg_addr == `PORT_A_OE_OFS);
  assign hit_b_oe    = (cfg_addr == `PORT_B_OE_OFS);
  assign hit_c_oe    = (cfg_addr == `PORT_C_OE_OFS);
  assign hit_d_oe    = (cfg_addr == `PORT_D_OE_OFS);

  // unusable drive bits are masked off before they are stored
  assign next_port_a_drive_type = (LARGE_PACKAGE != 0) ? cfg_wdata : `DRIVE_RESET;
  assign next_port_b_drive_type = cfg_wdata;
  assign next_port_c_drive_type = cfg_wdata & `C_OD_MASK;
  assign next_port_d_drive_type = cfg_wdata & D_SLEW_MASK;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      repeater_rd_data <= 8'h00;
    end else if (repeater_rd_drive) begin
      repeater_rd_data <= port_a_rd_byte;
    end
  end

  // drive-select registers; unusable bits are never stored and read zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port_a_drive_type <= `DRIVE_RESET;
    end else if (cfg_wr && hit_a_drive) begin
      port_a_drive_type <= next_port_a_drive_type;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port_b_drive_type <= `DRIVE_RESET;
    end else if (cfg_wr && hit_b_drive) begin
      port_b_drive_type <= next_port_b_drive_type;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port_c_drive_type <= `DRIVE_RESET;
    end else if (cfg_wr && hit_c_drive) begin
      port_c_drive_type <= next_port_c_drive_type;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port_d_drive_type <= `DRIVE_RESET;
    end else if (cfg_wr && hit_d_drive) begin
      port_d_drive_type <= next_port_d_drive_type;
    end
  end

  // read decode; unmapped offsets answer zero
  always @* begin
    next_rdata = `READ_UNMAPPED;
    if (hit_a_drive) begin
      next_rdata = port_a_drive_type;
    end else if (hit_b_drive) begin
      next_rdata = port_b_drive_type;
    end else if (hit_c_drive) begin
      next_rdata = port_c_drive_type;
    end else if (hit_d_drive) begin
      next_rdata = port_d_drive_type;
    end else if (hit_a_oe) begin
      next_rdata = port_a_oe_state;
    end else if (hit_b_oe) begin
      next_rdata = port_b_oe_state;
    end else if (hit_c_oe) begin
      next_rdata = port_c_oe_state;
    end else if (hit_d_oe) begin
      next_rdata = port_d_oe_state;
    end
  end

  // a read in the same edge as a write returns the old value
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= next_rdata;
    end
  end

  // port a: upper nibble open drain, lower nibble slew, absent on small package
  genvar ia;
  generate
    for (ia = 0; ia < PORT_WIDTH; ia = ia + 1) begin : gen_port_a
      port_pin_cell #(
        .PRESENT      (LARGE_PACKAGE),
        .OD_CAPABLE   (`AB_OD_MASK >> ia & 1),
        .SLEW_CAPABLE (`AB_SLEW_MASK >> ia & 1)
      ) u_pin (
        .clk        (clk),
        .reset      (reset),
        .drive_sel  (port_a_drive_type[ia]),
        .oe_request (port_a_oe_req[ia]),
        .data_out   (port_a_level[ia]),
        .pin_out    (port_a_pin_out[ia]),
        .pin_oe_n   (port_a_pin_oe_n[ia]),
        .slew_fast  (port_a_slew_fast[ia]),
        .oe_state   (port_a_oe_state[ia])
      );
    end
  endgenerate

  // port b: same layout as port a
  genvar ib;
  generate
    for (ib = 0; ib < PORT_WIDTH; ib = ib + 1) begin : gen_port_b
      port_pin_cell #(
        .PRESENT      (1),
        .OD_CAPABLE   (`AB_OD_MASK >> ib & 1),
        .SLEW_CAPABLE (`AB_SLEW_MASK >> ib & 1)
      ) u_pin (
        .clk        (clk),
        .reset      (reset),
        .drive_sel  (port_b_drive_type[ib]),
        .oe_request (port_b_oe_req[ib]),
        .data_out   (port_b_data[ib]),
        .pin_out    (port_b_pin_out[ib]),
        .pin_oe_n   (port_b_pin_oe_n[ib]),
        .slew_fast  (port_b_slew_fast[ib]),
        .oe_state   (port_b_oe_state[ib])
      );
    end
  endgenerate

  // port c: bits 6, 5, 1, 0 belong to the test port and never drive
  genvar ic;
  generate
    for (ic = 0; ic < 8; ic = ic + 1) begin : gen_port_c
      port_pin_cell #(
        .PRESENT      (`C_PIN_MASK >> ic & 1),
        .OD_CAPABLE   (`C_OD_MASK >> ic & 1),
        .SLEW_CAPABLE (0)
      ) u_pin (
        .clk        (clk),
        .reset      (reset),
        .drive_sel  (port_c_drive_type[ic]),
        .oe_request (port_c_oe_req[ic]),
        .data_out   (port_c_data[ic]),
        .pin_out    (port_c_pin_out[ic]),
        .pin_oe_n   (port_c_pin_oe_n[ic]),
        .slew_fast  (),
        .oe_state   (port_c_oe_state[ic])
      );
    end
  endgenerate

  // port d: pins 1 and 2 only, pin 2 only on the large package
  genvar id;
  generate
    for (id = 0; id < 8; id = id + 1) begin : gen_port_d
      port_pin_cell #(
        .PRESENT      (D_PIN_MASK >> id & 1),
        .OD_CAPABLE   (0),
        .SLEW_CAPABLE (D_SLEW_MASK >> id & 1)
      ) u_pin (
        .clk        (clk),
        .reset      (reset),
        .drive_sel  (port_d_drive_type[id]),
        .oe_request (port_d_oe_req[id]),
        .data_out   (port_d_data[id]),
        .pin_out    (port_d_pin_out[id]),
        .pin_oe_n   (port_d_pin_oe_n[id]),
        .slew_fast  (port_d_slew_fast[id]),
        .oe_state   (port_d_oe_state[id])
      );
    end
  endgenerate

endmodule

// ===== sim/port_repeater_and_drive_ctl_monitor.sv
// assertion checker for the port drive control block
`timescale 1ns/1ps
module port_repeater_and_drive_ctl_monitor (
  input wire       clk,                  // clock
  input wire       reset,                // async reset
  input wire       cfg_rd,               // read strobe
  input wire [7:0] cfg_rdata,            // read data
  input wire [7:0] memory_map_ctl,       // enable bit 7
  input wire       port_a_repeater_mode, // static mode
  input wire       periph_range_sel_a,   // range a
  input wire       periph_range_sel_b,   // range b
  input wire       cpu_rd_n,             // read strobe
  input wire       cpu_wr_n,             // write strobe
  input wire [7:0] cpu_wr_data,          // write byte
  input wire [7:0] repeater_rd_data,     // read byte
  input wire       repeater_rd_drive,    // read active
  input wire [7:0] port_a_pin_in,        // port a wire
  input wire [7:0] port_a_pin_out,       // port a out
  input wire [7:0] port_a_pin_oe_n,      // port a enable
  input wire [7:0] port_b_dir,           // port b dir
  input wire [7:0] port_b_array_oe,      // port b term
  input wire [7:0] port_b_pin_oe_n,      // port b enable
  input wire [7:0] port_c_pin_out,       // port c out
  input wire [7:0] port_c_pin_oe_n,      // port c enable
  input wire [7:0] port_d_pin_oe_n       // port d enable
);
  wire rep_on = memory_map_ctl[7] & port_a_repeater_mode & (periph_range_sel_a | periph_range_sel_b);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_pio_wr;
    rep_on && !cpu_wr_n && cpu_rd_n;
  endsequence
  sequence s_pio_rd;
    rep_on && !cpu_rd_n && cpu_wr_n;
  endsequence
  a_rd_drive_gate: assert property (repeater_rd_drive == (rep_on && !cpu_rd_n && cpu_wr_n))
    else $error("repeater read drive wrong");
  a_wr_drives_port: assert property (s_pio_wr |=> port_a_pin_oe_n[3:0] == 4'h0 &&
    port_a_pin_out[3:0] == $past(cpu_wr_data[3:0])) else $error("repeater write not driven");
  a_idle_no_drive: assert property (port_a_repeater_mode && !(rep_on && !cpu_wr_n) |=>
    port_a_pin_oe_n == 8'hFF) else $error("port a driven outside repeater write");
  a_rd_capture: assert property (s_pio_rd |=> repeater_rd_data == $past(port_a_pin_in))
    else $error("repeater read byte wrong");
  a_test_pins_off: assert property (port_c_pin_oe_n[6:5] == 2'b11 && port_c_pin_oe_n[1:0] == 2'b11 &&
    (port_c_pin_out & 8'h63) == 8'h00) else $error("test pin driven");
  a_d_unused_off: assert property (port_d_pin_oe_n[7:3] == 5'h1F && port_d_pin_oe_n[0])
    else $error("unused port d pin driven");
  a_b_enable_or: assert property (1'b1 |=> port_b_pin_oe_n[3:0] ==
    ~($past(port_b_dir[3:0]) | $past(port_b_array_oe[3:0]))) else $error("port b enable wrong");
  a_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read data changed without read");
endmodule

// ===== sim/periph_model.sv
// parallel peripheral on the repeater port
`timescale 1ns/1ps
module periph_model (
  input  wire       clk,      // clock
  input  wire       sel,      // chosen by decode
  input  wire       cpu_rd_n, // read strobe
  input  wire       slow,     // data one cycle late
  input  wire [7:0] pin_out,  // pad levels
  input  wire [7:0] pin_oe_n, // pad enables
  output wire [7:0] pin_in    // resolved wire
);
  reg  [7:0] mem = 8'h00;
  reg  [7:0] last = 8'h00;
  reg        seen = 1'b0;
  wire       drv = sel & ~cpu_rd_n & (~slow | seen);
  // released lines show the stored byte while the peripheral drives, else the inverse of their last level
  assign pin_in = (pin_out & ~pin_oe_n) | (pin_oe_n & (drv ? mem : ~last));
  always @(posedge clk) begin
    if (sel && pin_oe_n == 8'h00) mem <= pin_out;
    seen <= sel & ~cpu_rd_n;
    last <= pin_in;
  end
endmodule

// ===== sim/port_repeater_and_drive_ctl_tb.sv
// self-checking bench for the port drive control block
`timescale 1ns/1ps
module port_repeater_and_drive_ctl_tb;
  reg        clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, cpu_rd_n = 1'b1, cpu_wr_n = 1'b1;
  reg        slow = 1'b0, port_a_repeater_mode = 1'b1, periph_range_sel_a = 1'b0, periph_range_sel_b = 1'b0;
  reg  [7:0] cfg_addr = '0, cfg_wdata = '0, memory_map_ctl = '0, cpu_wr_data = '0;
  reg  [7:0] port_a_data = '0, port_a_dir = '0, port_a_array_oe = '0, port_b_data = '0, port_b_dir = '0;
  reg  [7:0] port_b_array_oe = '0, port_c_data = '0, port_c_dir = '0, port_c_array_oe = '0;
  reg  [7:0] port_d_data = '0, port_d_dir = '0, port_d_array_oe = '0;
  wire [7:0] cfg_rdata, repeater_rd_data, port_a_pin_in, port_a_pin_out, port_a_pin_oe_n, port_a_slew_fast;
  wire [7:0] port_b_pin_out, port_b_pin_oe_n, port_b_slew_fast, port_c_pin_out, port_c_pin_oe_n;
  wire [7:0] port_d_pin_out, port_d_pin_oe_n, port_d_slew_fast;
  wire       repeater_rd_drive;
  reg  [7:0] qc[$], qr[$], drv[4], v, got, eb, ec, ed, ea, oa;
  reg  [7:0] ofs[8] = '{8'h08, 8'h09, 8'h16, 8'h17, 8'h0C, 8'h0D, 8'h1A, 8'h1B};
  reg        rd_seen = 1'b0, act;
  int        errors = 0, compares = 0, i, k;

  always #5 clk = ~clk;

  port_repeater_and_drive_ctl uut (.clk, .reset, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata,
    .memory_map_ctl, .port_a_repeater_mode, .periph_range_sel_a, .periph_range_sel_b, .cpu_rd_n, .cpu_wr_n,
    .cpu_wr_data, .repeater_rd_data, .repeater_rd_drive, .port_a_data, .port_a_dir, .port_a_array_oe,
    .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe_n, .port_a_slew_fast, .port_b_data, .port_b_dir,
    .port_b_array_oe, .port_b_pin_out, .port_b_pin_oe_n, .port_b_slew_fast, .port_c_data, .port_c_dir,
    .port_c_array_oe, .port_c_pin_out, .port_c_pin_oe_n, .port_d_data, .port_d_dir, .port_d_array_oe,
    .port_d_pin_out, .port_d_pin_oe_n, .port_d_slew_fast);
  periph_model peer (.clk, .sel(periph_range_sel_a | periph_range_sel_b), .cpu_rd_n, .slow,
    .pin_out(port_a_pin_out), .pin_oe_n(port_a_pin_oe_n), .pin_in(port_a_pin_in));

  task chk(input [7:0] seen, input [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cfg_write(input [7:0] a, input [7:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task cfg_read(input [7:0] a, input [7:0] exp);
    @(negedge clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    qc.push_back(exp);
    @(negedge clk);
    cfg_rd = 1'b0;
  endtask
  task end_of_test;
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // result watchers: register reads one cycle on, repeater reads at strobe release
  always @(posedge clk) rd_seen <= cfg_rd;
  always @(negedge clk) if (rd_seen) chk(cfg_rdata, qc.pop_front());
  always @(posedge cpu_rd_n) if (qr.size() > 0) chk(repeater_rd_data, qr.pop_front());

  initial begin
    #100000;
    errors++;
    end_of_test;
  end

  initial begin
    i = $urandom(32'h76fe_0bcb);
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    for (i = 0; i < 8; i++) cfg_read(ofs[i], 8'h00);
    cfg_read(8'h3F, 8'h00);
    for (k = 0; k < 24; k++) begin
      @(negedge clk);
      {port_a_data, port_a_dir, port_a_array_oe, port_b_data} = $urandom;
      {port_b_dir, port_b_array_oe, port_c_data, port_c_dir} = $urandom & 32'h3FFF_FFFF;
      {port_c_array_oe, port_d_data, port_d_dir, port_d_array_oe} = $urandom;
      port_a_repeater_mode = k[0];
      for (i = 0; i < 4; i++) begin
        drv[i] = $urandom;
        cfg_write(ofs[i], drv[i]);
      end
      cfg_write(ofs[4 + k % 4], 8'($urandom));
      eb = (port_b_dir | port_b_array_oe) & ~(drv[1] & 8'hF0 & port_b_data);
      ec = (port_c_dir | port_c_array_oe) & 8'h9C & ~(drv[2] & 8'h9C & port_c_data);
      ed = (port_d_dir | port_d_array_oe) & 8'h06;
      ea = port_a_repeater_mode ? 8'h00 : (port_a_dir | port_a_array_oe);
      oa = ea & ~(drv[0] & 8'hF0 & port_a_data);
      chk(port_a_pin_out & oa, port_a_data & oa);
      chk(port_d_pin_out & (ed | 8'hF9), port_d_data & ed);
      chk(port_b_pin_oe_n, ~eb);
      chk(port_b_pin_out & eb, port_b_data & eb);
      chk(port_c_pin_oe_n, ~ec);
      chk(port_c_pin_out & ec, port_c_data & ec);
      chk(port_d_pin_oe_n, ~ed);
      chk(port_a_slew_fast & 8'h0F, drv[0] & 8'h0F);
      chk(port_b_slew_fast & 8'h0F, drv[1] & 8'h0F);
      chk(port_d_slew_fast & 8'h06, drv[3] & 8'h06);
      chk(port_a_pin_oe_n, ~oa);
      cfg_read(8'h08, drv[0]);
      cfg_read(8'h09, drv[1]);
      cfg_read(8'h16, drv[2] & 8'h9C);
      cfg_read(8'h17, drv[3] & 8'h06);
      cfg_read(8'h0C, ea);
      cfg_read(8'h0D, port_b_dir | port_b_array_oe);
      cfg_read(8'h1A, (port_c_dir | port_c_array_oe) & 8'h9C);
      cfg_read(8'h1B, (port_d_dir | port_d_array_oe) & 8'h06);
    end
    cfg_write(8'h08, 8'h00);
    got = 8'h00;
    for (k = 0; k < 16; k++) begin
      @(negedge clk);
      memory_map_ctl = {k[2], 7'($urandom)};
      periph_range_sel_a = k[0];
      periph_range_sel_b = k[1];
      slow = k[3];
      act = k[2] & (k[0] | k[1]);
      v = $urandom;
      cpu_wr_data = v;
      cpu_wr_n = 1'b0;
      cfg_read(8'h0C, act ? 8'hFF : 8'h00);
      cpu_wr_n = 1'b1;
      got = act ? v : got;
      @(negedge clk);
      cpu_rd_n = 1'b0;
      qr.push_back(got);
      repeat (2) @(negedge clk);
      cpu_rd_n = 1'b1;
    end
    repeat (3) @(negedge clk);
    end_of_test;
  end
endmodule

bind port_repeater_and_drive_ctl port_repeater_and_drive_ctl_monitor mon (.clk, .reset, .cfg_rd, .cfg_rdata,
  .memory_map_ctl, .port_a_repeater_mode, .periph_range_sel_a, .periph_range_sel_b, .cpu_rd_n, .cpu_wr_n,
  .cpu_wr_data, .repeater_rd_data, .repeater_rd_drive, .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe_n,
  .port_b_dir, .port_b_array_oe, .port_b_pin_oe_n, .port_c_pin_out, .port_c_pin_oe_n, .port_d_pin_oe_n);
